// *** core/ppc_pkg.sv ***
// Constants for the port 1 PHY control and status register bank.
// Assumes a 32-bit AXI4-Lite slave; printed offsets are register
// indices, and each byte address is four times the index.
package ppc_pkg;

  localparam int unsigned PPC_ADDR_W = 12;
  localparam int unsigned PPC_REG_W  = 16;
  localparam int unsigned PPC_IDX_W  = 10;

  // Register indices; byte address = index * 4
  localparam logic [9:0] PPC_IDX_PORT_CTRL     = 10'h07e;
  localparam logic [9:0] PPC_IDX_LINK_STATUS   = 10'h080;
  localparam logic [9:0] PPC_IDX_RESERVED_GAP  = 10'h082;
  localparam logic [9:0] PPC_IDX_BASIC_CTRL    = 10'h090;
  localparam logic [9:0] PPC_IDX_BASIC_STATUS  = 10'h091;
  localparam logic [9:0] PPC_IDX_AUTONEG_ADV   = 10'h092;
  localparam logic [9:0] PPC_IDX_PARTNER_ABL   = 10'h093;
  localparam logic [9:0] PPC_IDX_SPECIAL_CTRL  = 10'h094;

  // port1_phy_control field positions
  localparam int unsigned PC_TX_DIS     = 14;
  localparam int unsigned PC_AN_RESTART = 13;
  localparam int unsigned PC_FEF_DIS    = 12;
  localparam int unsigned PC_PWR_DOWN   = 11;
  localparam int unsigned PC_MDIX_DIS   = 10;
  localparam int unsigned PC_FORCE_MDIX = 9;
  localparam int unsigned PC_FAR_LOOP   = 8;
  localparam int unsigned PC_AN_EN      = 7;
  localparam int unsigned PC_SPEED100   = 6;
  localparam int unsigned PC_FULL_DUP   = 5;
  localparam int unsigned PC_ADV_LSB    = 0;
  localparam int unsigned PC_ADV_W      = 5;
  localparam logic [15:0] PC_RESET      = 16'h00ff;
  // Bits software may store (15 reserved reads zero)
  localparam logic [15:0] PC_RW_MASK    = 16'h7fff;

  // port1_link_status field positions
  localparam int unsigned LS_STD_XOVER  = 15;
  localparam int unsigned LS_POL_REV    = 13;
  localparam int unsigned LS_TX_FC      = 12;
  localparam int unsigned LS_RX_FC      = 11;
  localparam int unsigned LS_SPEED100   = 10;
  localparam int unsigned LS_FULL_DUP   = 9;
  localparam int unsigned LS_FEF        = 8;
  localparam int unsigned LS_MDIX       = 7;
  localparam int unsigned LS_AN_DONE    = 6;
  localparam int unsigned LS_LINK       = 5;
  localparam logic        LS_STD_XOVER_RESET = 1'b1;

  // phy1_basic_control alias positions
  localparam int unsigned BC_LOOP       = 14;
  localparam int unsigned BC_SPEED100   = 13;
  localparam int unsigned BC_AN_EN      = 12;
  localparam int unsigned BC_PWR_DOWN   = 11;
  localparam int unsigned BC_AN_RESTART = 9;
  localparam int unsigned BC_FULL_DUP   = 8;
  localparam int unsigned BC_STD_XOVER  = 5;
  localparam int unsigned BC_FORCE_MDIX = 4;
  localparam int unsigned BC_MDIX_DIS   = 3;
  localparam int unsigned BC_FEF_DIS    = 2;
  localparam int unsigned BC_TX_DIS     = 1;

  // phy1_basic_status alias positions
  localparam int unsigned BS_AN_DONE    = 5;
  localparam int unsigned BS_FEF        = 4;
  localparam int unsigned BS_LINK       = 2;

  // phy1_autoneg_advert / phy1_partner_ability positions
  localparam int unsigned AD_PAUSE      = 10;
  localparam int unsigned AD_100FD      = 8;
  localparam int unsigned AD_100HD      = 7;
  localparam int unsigned AD_10FD       = 6;
  localparam int unsigned AD_10HD       = 5;

  // phy1_special_control alias positions
  localparam int unsigned SC_POL_REV    = 5;
  localparam int unsigned SC_MDIX       = 4;

  localparam logic [1:0] PPC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PPC_RESP_SLVERR = 2'b10;

endpackage : ppc_pkg

// *** core/ppc_port1_phy_regs.sv ***
// Port 1 PHY control/status register bank behind an AXI4-Lite slave.
// Assumes PHY status inputs come from logic on clk; PHY control
// outputs are consumed by the PHY core on the same clock.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - Control bit 14 set turns the port transmitter off.
// - Writing 1 to bit 13 restarts auto-negotiation; bit then self-clears.
// - Control bit 12 disables far-end-fault detection in fiber mode.
// - Control bit 11 powers the PHY down; registers keep their values.
// - Control bit 10 set disables automatic crossover detection.
// - With crossover detection off, bit 9 forces MDI-X mode.
// - Control bit 8 loops port 2 traffic back at port 1 PHY.
// - Bit 7 enables auto-negotiation, resets 1; else bits 6:5 decide.
// - Without auto-negotiation, bit 6 forces 100 or 10 Mbps; resets 1.
// - Bit 5 forces duplex; failed auto-negotiation always gives half.
// - Bits 4:0, reset 1, advertise pause and four speed/duplex abilities.
// - Status bit 15 writable, resets 1, selects standard crossover algorithm.
// - Status bit 13 reads 1 when receive polarity is reversed.
// - Status bits 12 and 11 show transmit and receive flow control.
// - Status bit 10 reads 1 for resolved 100 Mbps link speed.
// - Status bit 9 reads 1 for resolved full duplex link.
// - Status bit 8 reads 1 on far-end fault in fiber operation.
// - Status bit 7 shows crossover state, 0 MDI, 1 MDI-X.
// - Status bit 6 reads 1 once auto-negotiation has completed.
// - Status bit 5 reads 1 while the link is good.
// - Status bits 4:0 show the link partner's advertised abilities.
module ppc_port1_phy_regs
  import ppc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AXI4-Lite slave
  input  wire logic [PPC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [PPC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Controls to the PHY core
  output logic                       txDisable,
  output logic                       anRestart,
  output logic                       farEndFaultDisable,
  output logic                       powerDown,
  output logic                       autoMdixDisable,
  output logic                       forceMdix,
  output logic                       farEndLoopback,
  output logic                       anEnable,
  output logic                       forceSpeed100,
  output logic                       forceFullDuplex,
  output logic [PC_ADV_W-1:0]        advertise,
  output logic                       standardCrossoverSel,
  // Status from the PHY core and MAC
  input  wire logic                  fiberMode,
  input  wire logic                  polarityReversed,
  input  wire logic                  txFlowActive,
  input  wire logic                  rxFlowActive,
  input  wire logic                  anSpeed100,
  input  wire logic                  anFullDuplex,
  input  wire logic                  farEndFaultSeen,
  input  wire logic                  mdixDetected,
  input  wire logic                  anDone,
  input  wire logic                  linkGood,
  input  wire logic [PC_ADV_W-1:0]   partnerAbility
);

  // Shared storage: one copy of each control bit, viewed at two addresses
  logic [15:0]             ctrl_r;
  logic [15:0]             ctrlNxt;
  logic                    stdXover_r;
  logic                    stdXoverNxt;

  logic [PPC_ADDR_W-1:0]   awAddr_r;
  logic                    awHeld_r;
  logic [15:0]             wData_r;
  logic [1:0]              wStrb_r;
  logic                    wHeld_r;
  logic                    doWrite;
  logic [PPC_IDX_W-1:0]    wIdx;
  logic [PPC_IDX_W-1:0]    rIdx;
  logic [15:0]             laneMask;
  logic [15:0]             wSet;
  logic                    wHit;
  logic [15:0]             rVal;
  logic                    rHit;

  // Resolved status
  logic                    opSpeed100;
  logic                    opFullDuplex;
  logic                    opMdix;
  logic                    opFef;
  logic [15:0]             statusWord;

  assign wIdx     = awAddr_r[PPC_ADDR_W-1:2];
  assign rIdx     = s_axi_araddr[PPC_ADDR_W-1:2];
  assign laneMask = {{8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  assign wSet     = wData_r & laneMask;

  // Write address and data are taken independently, in either order
  assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
  assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata[15:0];
      wStrb_r <= s_axi_wstrb[1:0];
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // Decode a write into the shared control storage
  always_comb begin
    ctrlNxt     = ctrl_r;
    stdXoverNxt = stdXover_r;
    wHit        = 1'b1;
    ctrlNxt[PC_AN_RESTART] = 1'b0;
    if (doWrite) begin
      unique case (wIdx)
        PPC_IDX_PORT_CTRL: begin
          ctrlNxt = (ctrl_r & ~(laneMask & PC_RW_MASK))
                  | (wSet & PC_RW_MASK);
          ctrlNxt[PC_AN_RESTART] = wSet[PC_AN_RESTART];
        end
        PPC_IDX_LINK_STATUS: begin
          if (wStrb_r[1]) begin
            stdXoverNxt = wData_r[LS_STD_XOVER];
          end
        end
        PPC_IDX_BASIC_CTRL: begin
          if (wStrb_r[1]) begin
            ctrlNxt[PC_FAR_LOOP]   = wData_r[BC_LOOP];
            ctrlNxt[PC_SPEED100]   = wData_r[BC_SPEED100];
            ctrlNxt[PC_AN_EN]      = wData_r[BC_AN_EN];
            ctrlNxt[PC_PWR_DOWN]   = wData_r[BC_PWR_DOWN];
            ctrlNxt[PC_AN_RESTART] = wData_r[BC_AN_RESTART];
            ctrlNxt[PC_FULL_DUP]   = wData_r[BC_FULL_DUP];
          end
          if (wStrb_r[0]) begin
            stdXoverNxt            = wData_r[BC_STD_XOVER];
            ctrlNxt[PC_FORCE_MDIX] = wData_r[BC_FORCE_MDIX];
            ctrlNxt[PC_MDIX_DIS]   = wData_r[BC_MDIX_DIS];
            ctrlNxt[PC_FEF_DIS]    = wData_r[BC_FEF_DIS];
            ctrlNxt[PC_TX_DIS]     = wData_r[BC_TX_DIS];
          end
        end
        PPC_IDX_AUTONEG_ADV: begin
          if (wStrb_r[1]) begin
            ctrlNxt[4] = wData_r[AD_PAUSE];
            ctrlNxt[3] = wData_r[AD_100FD];
          end
          if (wStrb_r[0]) begin
            ctrlNxt[2] = wData_r[AD_100HD];
            ctrlNxt[1] = wData_r[AD_10FD];
            ctrlNxt[0] = wData_r[AD_10HD];
          end
        end
        PPC_IDX_RESERVED_GAP, PPC_IDX_BASIC_STATUS,
        PPC_IDX_PARTNER_ABL, PPC_IDX_SPECIAL_CTRL: begin
          wHit = 1'b1;
        end
        default: begin
          wHit = 1'b0;
        end
      endcase
    end
  end

  // Power-down is just another stored bit, so nothing else is touched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= PC_RESET;
      stdXover_r <= LS_STD_XOVER_RESET;
    end else begin
      ctrl_r     <= ctrlNxt;
      stdXover_r <= stdXoverNxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PPC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wHit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Controls to the PHY come straight from storage; forceMdix is bit 9 gated by bit 10
  assign txDisable            = ctrl_r[PC_TX_DIS];
  assign anRestart            = ctrl_r[PC_AN_RESTART];
  assign farEndFaultDisable   = ctrl_r[PC_FEF_DIS];
  assign powerDown            = ctrl_r[PC_PWR_DOWN];
  assign autoMdixDisable      = ctrl_r[PC_MDIX_DIS];
  assign forceMdix            = ctrl_r[PC_MDIX_DIS]
                              & ctrl_r[PC_FORCE_MDIX];
  assign farEndLoopback       = ctrl_r[PC_FAR_LOOP];
  assign anEnable             = ctrl_r[PC_AN_EN];
  assign forceSpeed100        = ctrl_r[PC_SPEED100];
  assign forceFullDuplex      = ctrl_r[PC_FULL_DUP];
  assign advertise            = ctrl_r[PC_ADV_LSB +: PC_ADV_W];
  assign standardCrossoverSel = stdXover_r;

  // Resolved operating state as software sees it
  assign opSpeed100   = ctrl_r[PC_AN_EN] ? anSpeed100
                                         : ctrl_r[PC_SPEED100];
  assign opFullDuplex = ctrl_r[PC_AN_EN] ? (anDone & anFullDuplex)
                                         : ctrl_r[PC_FULL_DUP];
  assign opMdix       = ctrl_r[PC_MDIX_DIS] ? ctrl_r[PC_FORCE_MDIX]
                                            : mdixDetected;
  // Fault masked when disabled or outside fiber mode
  assign opFef        = farEndFaultSeen & fiberMode
                      & ~ctrl_r[PC_FEF_DIS];

  always_comb begin
    statusWord               = '0;
    statusWord[LS_STD_XOVER] = stdXover_r;
    statusWord[LS_POL_REV]   = polarityReversed;
    statusWord[LS_TX_FC]     = txFlowActive;
    statusWord[LS_RX_FC]     = rxFlowActive;
    statusWord[LS_SPEED100]  = opSpeed100;
    statusWord[LS_FULL_DUP]  = opFullDuplex;
    statusWord[LS_FEF]       = opFef;
    statusWord[LS_MDIX]      = opMdix;
    statusWord[LS_AN_DONE]   = anDone;
    statusWord[LS_LINK]      = linkGood;
    statusWord[4:0]          = partnerAbility;
  end

  // Read decode; reserved and unused bits read as zero
  always_comb begin
    rVal = '0;
    rHit = 1'b1;
    unique case (rIdx)
      PPC_IDX_PORT_CTRL: begin
        rVal = ctrl_r & PC_RW_MASK;
      end
      PPC_IDX_LINK_STATUS: begin
        rVal = statusWord;
      end
      PPC_IDX_RESERVED_GAP: begin
        rVal = '0;
      end
      PPC_IDX_BASIC_CTRL: begin
        rVal[BC_LOOP]       = ctrl_r[PC_FAR_LOOP];
        rVal[BC_SPEED100]   = ctrl_r[PC_SPEED100];
        rVal[BC_AN_EN]      = ctrl_r[PC_AN_EN];
        rVal[BC_PWR_DOWN]   = ctrl_r[PC_PWR_DOWN];
        rVal[BC_AN_RESTART] = ctrl_r[PC_AN_RESTART];
        rVal[BC_FULL_DUP]   = ctrl_r[PC_FULL_DUP];
        rVal[BC_STD_XOVER]  = stdXover_r;
        rVal[BC_FORCE_MDIX] = ctrl_r[PC_FORCE_MDIX];
        rVal[BC_MDIX_DIS]   = ctrl_r[PC_MDIX_DIS];
        rVal[BC_FEF_DIS]    = ctrl_r[PC_FEF_DIS];
        rVal[BC_TX_DIS]     = ctrl_r[PC_TX_DIS];
      end
      PPC_IDX_BASIC_STATUS: begin
        rVal[BS_AN_DONE] = anDone;
        rVal[BS_FEF]     = opFef;
        rVal[BS_LINK]    = linkGood;
      end
      PPC_IDX_AUTONEG_ADV: begin
        rVal[AD_PAUSE] = ctrl_r[4];
        rVal[AD_100FD] = ctrl_r[3];
        rVal[AD_100HD] = ctrl_r[2];
        rVal[AD_10FD]  = ctrl_r[1];
        rVal[AD_10HD]  = ctrl_r[0];
      end
      PPC_IDX_PARTNER_ABL: begin
        rVal[AD_PAUSE] = partnerAbility[4];
        rVal[AD_100FD] = partnerAbility[3];
        rVal[AD_100HD] = partnerAbility[2];
        rVal[AD_10FD]  = partnerAbility[1];
        rVal[AD_10HD]  = partnerAbility[0];
      end
      PPC_IDX_SPECIAL_CTRL: begin
        rVal[SC_POL_REV] = polarityReversed;
        rVal[SC_MDIX]    = opMdix;
      end
      default: begin
        rHit = 1'b0;
      end
    endcase
  end

  // One read at a time; address taken only while no data is pending
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= PPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rVal};
      s_axi_rresp  <= rHit ? PPC_RESP_OKAY : PPC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ppc_port1_phy_regs

// *** dv/ppc_port1_phy_regs_assertions.sv ***
// Checker for the port 1 PHY control and status register bank.
// Sees only top-level ports; bound to every instance of the bank.
`timescale 1ns/1ps
module ppc_port1_phy_regs_assertions
  import ppc_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                anRestart,
  input wire logic                forceMdix,
  input wire logic                autoMdixDisable,
  input wire logic                txDisable,
  input wire logic                powerDown,
  input wire logic                anEnable,
  input wire logic [PC_ADV_W-1:0] advertise,
  input wire logic                standardCrossoverSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_restart_pulse; anRestart |=> !anRestart; endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse held beyond one cycle");
  // A restart can only come from a completed write
  property p_restart_cause; anRestart |-> $rose(s_axi_bvalid); endproperty
  a_restart_cause: assert property (p_restart_cause)
    else $error("restart pulse without a write");
  property p_force_mdix; forceMdix |-> autoMdixDisable; endproperty
  a_force_mdix: assert property (p_force_mdix)
    else $error("MDI-X forced while auto crossover enabled");
  // Power-down, transmit disable, auto-negotiation enable and advertisement move only on a register write
  property p_ctrl_stable;
    !$stable({txDisable, powerDown, anEnable, advertise})
      |-> $rose(s_axi_bvalid);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable)
    else $error("control output changed without a write");
  property p_xover_stable;
    !$stable(standardCrossoverSel) |-> $rose(s_axi_bvalid);
  endproperty
  a_xover_stable: assert property (p_xover_stable)
    else $error("crossover select changed without a write");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read data not returned one cycle after address");
  property p_w_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_answer: assert property (p_w_answer)
    else $error("write response late");
  property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("new write accepted while response pending");
endmodule : ppc_port1_phy_regs_assertions

bind ppc_port1_phy_regs ppc_port1_phy_regs_assertions u_chk (
  .clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .anRestart, .forceMdix,
  .autoMdixDisable, .txDisable, .powerDown, .anEnable, .advertise,
  .standardCrossoverSel
);

// *** dv/ppc_port1_phy_regs_tb_top.sv ***
// Self-checking bench for the port 1 PHY register bank.
// Acts as AXI4-Lite master and drives PHY status inputs at random.
`timescale 1ns/1ps
module ppc_port1_phy_regs_tb_top;
  import ppc_pkg::*;
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        txDisable, anRestart, farEndFaultDisable, powerDown;
  logic        autoMdixDisable, forceMdix, farEndLoopback, anEnable;
  logic        forceSpeed100, forceFullDuplex, standardCrossoverSel, xs;
  logic [4:0]  advertise, partnerAbility;
  logic        fiberMode, polarityReversed, txFlowActive, rxFlowActive;
  logic        anSpeed100, anFullDuplex, farEndFaultSeen, mdixDetected;
  logic        anDone, linkGood;
  logic [14:0] stIn;
  logic [15:0] v, c;
  int          nFail, checksDone, nPulse, nExp, seedV;
  localparam logic [11:0] A_CTRL = {PPC_IDX_PORT_CTRL, 2'b00};
  localparam logic [11:0] A_ST   = {PPC_IDX_LINK_STATUS, 2'b00};
  localparam logic [11:0] A_BC   = {PPC_IDX_BASIC_CTRL, 2'b00};
  localparam logic [11:0] A_GAP  = {PPC_IDX_RESERVED_GAP, 2'b00};
  localparam logic [11:0] A_AD   = {PPC_IDX_AUTONEG_ADV, 2'b00};
  localparam logic [11:0] A_BS   = {PPC_IDX_BASIC_STATUS, 2'b00};
  localparam logic [11:0] A_PA   = {PPC_IDX_PARTNER_ABL, 2'b00};
  localparam logic [11:0] A_SC   = {PPC_IDX_SPECIAL_CTRL, 2'b00};

  assign {fiberMode, polarityReversed, txFlowActive, rxFlowActive,
          anSpeed100, anFullDuplex, farEndFaultSeen, mdixDetected,
          anDone, linkGood, partnerAbility} = stIn;

  ppc_port1_phy_regs u_dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .txDisable, .anRestart,
    .farEndFaultDisable, .powerDown, .autoMdixDisable, .forceMdix,
    .farEndLoopback, .anEnable, .forceSpeed100, .forceFullDuplex,
    .advertise, .standardCrossoverSel, .fiberMode, .polarityReversed,
    .txFlowActive, .rxFlowActive, .anSpeed100, .anFullDuplex,
    .farEndFaultSeen, .mdixDetected, .anDone, .linkGood, .partnerAbility
  );

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (anRestart === 1'b1) nPulse <= nPulse + 1;
  end

  // Expected status word from control value, crossover bit and inputs
  function automatic logic [15:0] expSt(input logic [15:0] k,
                                        input logic x, input logic [14:0] s);
    return {x, 1'b0, s[13], s[12], s[11], k[7] ? s[10] : k[6],
            k[7] ? (s[6] & s[9]) : k[5], s[8] & s[14] & ~k[12],
            k[10] ? k[9] : s[7], s[6], s[5], s[4:0]};
  endfunction : expSt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // bready and rready stay high, so responses are taken on arrival
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1'b1;
        r = s_axi_bresp;
      end
    end
  endtask : wr

  task automatic rdr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
  endtask : rdr

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : testDone

  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    testDone();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; stIn = '0; nFail = 0; checksDone = 0;
    nPulse = 0; nExp = 0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_bready = 1'b1; s_axi_rready = 1'b1;
    s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0;
    s_axi_wstrb = 4'h3; xs = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    seedV = $urandom(60);
    rdr(A_CTRL, rd, rs);
    chk(rd, 32'h0000_00ff);
    rdr(A_ST, rd, rs);
    chk(rd, {16'h0000, expSt(16'h00ff, 1'b1, stIn)});
    for (int i = 0; i < 48; i++) begin
      stIn <= 15'($urandom);
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      wr(A_CTRL, v, 4'h3, rs);
      chk({30'h0, rs}, {30'h0, PPC_RESP_OKAY});
      chk({txDisable, farEndFaultDisable, powerDown, autoMdixDisable,
           forceMdix, farEndLoopback, anEnable, forceSpeed100,
           forceFullDuplex, advertise}, {v[14], v[12], v[11], v[10],
           v[10] & v[9], v[8], v[7], v[6], v[5], v[4:0]});
      if (v[13]) nExp++;
      c = v & 16'h5fff;
      rdr(A_CTRL, rd, rs);
      chk(rd, {16'h0000, c});
      rdr(A_ST, rd, rs);
      chk(rd, {16'h0000, expSt(c, xs, stIn)});
    end
    // Alias view clears crossover select and all other aliased bits except transmit disable, which it sets, and pulses a restart
    wr(A_BC, 16'h0202, 4'h3, rs);
    nExp++;
    c = 16'h4000 | (c & 16'h001f);
    xs = 1'b0;
    rdr(A_CTRL, rd, rs);
    chk(rd, {16'h0000, c});
    chk({31'h0, standardCrossoverSel}, 32'h0000_0000);
    wr(A_ST, 16'hffff, 4'h3, rs);
    xs = 1'b1;
    rdr(A_ST, rd, rs);
    chk(rd, {16'h0000, expSt(c, xs, stIn)});
    wr(A_ST, 16'h0000, 4'h1, rs);
    rdr(A_ST, rd, rs);
    chk(rd, {16'h0000, expSt(c, xs, stIn)});
    wr(12'h300, 16'hffff, 4'h3, rs);
    chk({30'h0, rs}, {30'h0, PPC_RESP_SLVERR});
    rdr(12'h300, rd, rs);
    chk({rd[31:2], rs}, {30'h0, PPC_RESP_SLVERR});
    rdr(A_GAP, rd, rs);
    chk(rd, 32'h0000_0000);
    chk({30'h0, rs}, {30'h0, PPC_RESP_OKAY});
    // Advert view: pause, 100 full and 10 full on, the rest off
    wr(A_AD, 16'h0540, 4'h3, rs);
    c = (c & 16'hffe0) | 16'h001a;
    chk({27'h0, advertise}, 32'h0000_001a);
    rdr(A_AD, rd, rs);
    chk(rd, 32'h0000_0540);
    rdr(A_BC, rd, rs);
    v = {1'b0, c[8], c[6], c[7], c[11], 1'b0, c[13], c[5],
         2'b00, xs, c[9], c[10], c[12], c[14], 1'b0};
    chk(rd, {16'h0000, v});
    rdr(A_BS, rd, rs);
    v = {10'h000, stIn[6], stIn[8] & stIn[14] & ~c[12], 1'b0,
         stIn[5], 2'b00};
    chk(rd, {16'h0000, v});
    rdr(A_PA, rd, rs);
    v = {5'h00, stIn[4], 1'b0, stIn[3:0], 5'h00};
    chk(rd, {16'h0000, v});
    rdr(A_SC, rd, rs);
    v = {10'h000, stIn[13], c[10] ? c[9] : stIn[7], 4'h0};
    chk(rd, {16'h0000, v});
    rdr(A_CTRL, rd, rs);
    chk(rd, {16'h0000, c});
    repeat (2) @(posedge clk);
    chk(32'(nPulse), 32'(nExp));
    testDone();
  end
endmodule : ppc_port1_phy_regs_tb_top
